// ### hw/power_good_supervisor.sv
`timescale 1ns/1ps
module power_good_supervisor (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic fbBelowUv,
   input  wire logic fbInsideUvHyst,
   input  wire logic fbAboveOv,
   input  wire logic fbInsideOvHyst,
   input  wire logic overtempRising,
   input  wire logic overtempFalling,
   input  wire logic enableAboveRising,
   input  wire logic enableAboveFalling,
   input  wire logic supplyAboveLockout,
   input  wire logic supplyAboveLockoutHyst,
   input  wire logic hiccupRecover,
   output logic      powerGoodFlagOut,
   output logic      powerGoodFlagOe,
   output logic      softStartActive
);
   import pg_pkg::*;

   // One-hot soft-start states; the idle state follows reset or any illegal code
   typedef enum logic [2:0] {
      SS_IDLE = 3'b001,
      SS_RAMP = 3'b010,
      SS_DONE = 3'b100
   } ss_state_t;

   // Whole state in one record: sync stages, faults, soft start, pins
   typedef struct packed {
      // Two flops per comparator before any logic reads it
      logic [1:0]       fbUvSync;
      logic [1:0]       fbUvhSync;
      logic [1:0]       fbOvSync;
      logic [1:0]       fbOvhSync;
      logic [1:0]       otrSync;
      logic [1:0]       otfSync;
      logic [1:0]       enrSync;
      logic [1:0]       enfSync;
      logic [1:0]       vccSync;
      logic [1:0]       vcchSync;
      logic [1:0]       hicSync;
      // Latched fault sources, each with its own end condition
      logic             windowFault;
      logic             thermalFault;
      logic             enableFault;
      logic             supplyFault;
      // Soft-start sequencer and its limit counter
      ss_state_t        ss;
      logic [CNT_W-1:0] ssCount;
      // Flag drive, plus registered copies of the pins
      logic             flagLowReg;
      logic             flagOe;
      logic             ssBusy;
   } state_t;

   state_t stateReg, stateNext;
   // Views of the synchronised comparators and the soft-start trigger
   logic   outsideWindow;
   logic   inRegulation;
   logic   anyFault;
   logic   ssTrigger;
   // Thermal, enable and supply recovery edges plus the hiccup level, each one a soft-start trigger
   logic   thermalEnds;
   logic   enableEnds;
   logic   supplyEnds;
   logic   hiccupEnds;

   // One qualify/expired bundle per timer
   pg_timer_if filterIf();
   pg_timer_if releaseIf();

   // Excursions count only once they outlast the whole filter time
   pg_timer #(.CYCLES(FAULT_FILTER_CYC), .W(CNT_W)) faultFilter (
      .clk (clk),
      .rst (rst),
      .tif (filterIf)
   );

   // Release waits this long after the last fault and soft start end
   pg_timer #(.CYCLES(RELEASE_DELAY_CYC), .W(CNT_W)) releaseDelay (
      .clk (clk),
      .rst (rst),
      .tif (releaseIf)
   );

   // Comparator outputs after the second stage only
   always_comb begin
      outsideWindow = stateReg.fbUvSync[1] | stateReg.fbOvSync[1];
      inRegulation  = stateReg.fbUvhSync[1] & stateReg.fbOvhSync[1];
      anyFault      = stateReg.windowFault | stateReg.thermalFault
                    | stateReg.enableFault | stateReg.supplyFault;
   end

   // Timer qualifiers
   assign filterIf.qualify  = outsideWindow;
   assign releaseIf.qualify = !anyFault && stateReg.ss == SS_DONE;

   // Fault tracking, soft start sequencing and flag drive
   always_comb begin
      stateNext = stateReg;
      // Two-stage synchronisers on every analog comparator input
      stateNext.fbUvSync  = {stateReg.fbUvSync[0],  fbBelowUv};
      stateNext.fbUvhSync = {stateReg.fbUvhSync[0], fbInsideUvHyst};
      stateNext.fbOvSync  = {stateReg.fbOvSync[0],  fbAboveOv};
      stateNext.fbOvhSync = {stateReg.fbOvhSync[0], fbInsideOvHyst};
      stateNext.otrSync   = {stateReg.otrSync[0],   overtempRising};
      stateNext.otfSync   = {stateReg.otfSync[0],   overtempFalling};
      stateNext.enrSync   = {stateReg.enrSync[0],   enableAboveRising};
      stateNext.enfSync   = {stateReg.enfSync[0],   enableAboveFalling};
      stateNext.vccSync   = {stateReg.vccSync[0],   supplyAboveLockout};
      stateNext.vcchSync  = {stateReg.vcchSync[0],  supplyAboveLockoutHyst};
      stateNext.hicSync   = {stateReg.hicSync[0],   hiccupRecover};

      // Window fault: set after filtered excursion, clear inside hysteresis
      // Only the filter gates it; soft start plays no part here
      if (filterIf.expired) begin
         stateNext.windowFault = 1'b1;
      end else if (inRegulation) begin
         stateNext.windowFault = 1'b0;
      end
      // Set beats clear in each fault below
      // Thermal: set above the rising threshold, cleared below the falling one
      if (stateReg.otrSync[1]) begin
         stateNext.thermalFault = 1'b1;
      end else if (!stateReg.otfSync[1] && inRegulation) begin
         stateNext.thermalFault = 1'b0;
      end
      // Enable: any drop below the falling threshold sets it
      if (!stateReg.enfSync[1]) begin
         stateNext.enableFault = 1'b1;
      end else if (stateReg.enrSync[1] && inRegulation) begin
         stateNext.enableFault = 1'b0;
      end
      // Supply: set below level minus hysteresis, ends above the level
      if (!stateReg.vcchSync[1]) begin
         stateNext.supplyFault = 1'b1;
      end else if (stateReg.vccSync[1] && inRegulation) begin
         stateNext.supplyFault = 1'b0;
      end

      // A thermal, enable or supply fault that clears this cycle restarts the ramp
      thermalEnds = stateReg.thermalFault & ~stateNext.thermalFault;
      enableEnds  = stateReg.enableFault & ~stateNext.enableFault;
      supplyEnds  = stateReg.supplyFault & ~stateNext.supplyFault;
      // A held hiccup line keeps the ramp at its start; the count waits
      hiccupEnds  = stateReg.hicSync[1];
      ssTrigger   = thermalEnds | enableEnds | supplyEnds | hiccupEnds;

      // Soft start runs until regulation or the limit time
      unique case (stateReg.ss)
         SS_IDLE: begin
            stateNext.ssCount = '0;
            stateNext.ss      = SS_RAMP;
         end
         SS_RAMP: begin
            // Limit counts from the last trigger, not from the first
            if (inRegulation || stateReg.ssCount == CNT_W'(SOFT_LIMIT_CYC - 1)) begin
               stateNext.ss = SS_DONE;
            end else begin
               stateNext.ssCount = stateReg.ssCount + CNT_W'(1);
            end
         end
         SS_DONE: begin
            // Stays here until a trigger restarts the ramp
         end
         default: begin
            stateNext.ss = SS_IDLE;
         end
      endcase
      // A trigger wins over a ramp exit in the same cycle
      if (ssTrigger) begin
         stateNext.ss      = SS_RAMP;
         stateNext.ssCount = '0;
      end

      // Enable low pulls immediately, without waiting for the filter
      if (!stateReg.enfSync[1] || anyFault || stateReg.ss != SS_DONE) begin
         stateNext.flagLowReg = 1'b1;
      end else if (releaseIf.expired) begin
         stateNext.flagLowReg = 1'b0;
      end

      // Pins come straight from flops; these copies follow the next state
      stateNext.flagOe = ~stateNext.flagLowReg;
      stateNext.ssBusy = stateNext.ss != SS_DONE;
   end

   // One register stage for the whole record
   always_ff @(posedge clk) begin
      if (rst) begin
         // Enable and supply faults start set so the flag stays low
         stateReg             <= '0;
         stateReg.ss          <= SS_IDLE;
         stateReg.enableFault <= 1'b1;
         stateReg.supplyFault <= 1'b1;
         stateReg.flagLowReg  <= FLAG_RESET_LOW;
         stateReg.flagOe      <= ~FLAG_RESET_LOW;
         stateReg.ssBusy      <= 1'b1;
      end else begin
         stateReg <= stateNext;
      end
   end

   // Open drain: only ever drives zero; enable low means pulling
   assign powerGoodFlagOut = 1'b0;
   // The pin reads high only through the far side's pull-up
   assign powerGoodFlagOe  = stateReg.flagOe;
   assign softStartActive  = stateReg.ssBusy;
endmodule

// ### pkg/pg_pkg.sv
package pg_pkg;
   // Clock rate of the regulator's internal logic clock
   localparam int CLK_HZ = 10_000_000;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   // Filter and delay times, in microseconds
   localparam int FAULT_FILTER_US   = 20;
   localparam int RELEASE_DELAY_US  = 256;
   localparam int SOFT_LIMIT_US     = 5000;
   // Derived cycle counts: least times round up
   localparam int FAULT_FILTER_CYC  = (FAULT_FILTER_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int RELEASE_DELAY_CYC = (RELEASE_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SOFT_LIMIT_CYC    = (SOFT_LIMIT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W             = 16;
   // Reset value of the flag pin: pulled low
   localparam logic FLAG_RESET_LOW  = 1'b1;
endpackage

// ### pkg/pg_timer_if.sv
`timescale 1ns/1ps
interface pg_timer_if;
   logic qualify;
   logic expired;
   modport owner (output qualify, input expired);
   modport timer (input qualify, output expired);
endinterface

// ### hw/pg_timer.sv
`timescale 1ns/1ps
// Counts while qualify holds; restarts at zero when it drops
module pg_timer #(
   parameter int CYCLES = 1,
   parameter int W      = 16
) (
   input  wire logic   clk,
   input  wire logic   rst,
   pg_timer_if.timer   tif
);
   typedef struct packed {
      logic [W-1:0] count;
      logic         done;
   } state_t;
   state_t stateReg, stateNext;
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   // Restart on any dropout so only continuous conditions count
   always_comb begin
      stateNext = stateReg;
      if (!tif.qualify) begin
         stateNext.count = '0;
         stateNext.done  = 1'b0;
      end else if (!stateReg.done) begin
         if (stateReg.count == LAST) begin
            stateNext.done = 1'b1;
         end else begin
            stateNext.count = stateReg.count + W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stateReg <= '0;
      end else begin
         stateReg <= stateNext;
      end
   end

   assign tif.expired = stateReg.done;
endmodule

// ### verification/pg_pullup.sv
`timescale 1ns/1ps
// Far-side reset input with its pull-up on the flag net
module pg_pullup (
   input  wire logic flagOut,
   input  wire logic flagOe,
   output wire logic pinLevel
);
   // Released pin rises to the rail; the block can only sink
   assign pinLevel = flagOe ? 1'b1 : flagOut;
endmodule

// ### verification/pg_props.sv
`timescale 1ns/1ps
module pg_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic fbBelowUv,
   input wire logic fbInsideUvHyst,
   input wire logic fbAboveOv,
   input wire logic fbInsideOvHyst,
   input wire logic overtempRising,
   input wire logic overtempFalling,
   input wire logic enableAboveRising,
   input wire logic enableAboveFalling,
   input wire logic supplyAboveLockout,
   input wire logic supplyAboveLockoutHyst,
   input wire logic hiccupRecover,
   input wire logic powerGoodFlagOut,
   input wire logic powerGoodFlagOe,
   input wire logic softStartActive
);
   import pg_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [15:0] goodCnt;
   logic [15:0] runLen;
   logic        winBadReg;
   wire         winBad = fbBelowUv | fbAboveOv;
   wire         allGood = enableAboveRising & enableAboveFalling & supplyAboveLockout
                        & supplyAboveLockoutHyst & !overtempRising & !overtempFalling
                        & fbInsideUvHyst & fbInsideOvHyst & !winBad;
   // Run lengths seen at the pins; sync stages only make the design later
   always_ff @(posedge clk) begin
      if (rst) begin
         goodCnt <= 16'h0;
         runLen <= 16'h0;
      end else begin
         goodCnt <= allGood ? goodCnt + {15'h0, goodCnt != 16'hffff} : 16'h0;
         if (winBad) runLen <= winBadReg ? runLen + 16'h1 : 16'h1;
      end
      winBadReg <= winBad;
   end
   property p_drain; powerGoodFlagOut == 1'b0; endproperty
   a_drain: assert property (p_drain) else $error("flag data not low");
   property p_release; $rose(powerGoodFlagOe) |-> goodCnt >= RELEASE_DELAY_CYC; endproperty
   a_release: assert property (p_release) else $error("early release");
   property p_window; winBad && runLen == FAULT_FILTER_CYC + 8 |-> !powerGoodFlagOe; endproperty
   a_window: assert property (p_window) else $error("window fault missed");
   property p_enoff; $fell(enableAboveFalling) |-> ##[1:6] !powerGoodFlagOe; endproperty
   a_enoff: assert property (p_enoff) else $error("enable low missed");
   property p_temp; $rose(overtempRising) |-> ##[1:6] !powerGoodFlagOe; endproperty
   a_temp: assert property (p_temp) else $error("overtemp missed");
   property p_lockout; $fell(supplyAboveLockoutHyst) |-> ##[1:6] !powerGoodFlagOe; endproperty
   a_lockout: assert property (p_lockout) else $error("lockout missed");
   property p_restart; $rose(hiccupRecover) |-> ##[1:6] softStartActive; endproperty
   a_restart: assert property (p_restart) else $error("no soft start");
   property p_soft; softStartActive [*3] |-> !powerGoodFlagOe; endproperty
   a_soft: assert property (p_soft) else $error("released in soft start");
endmodule
bind power_good_supervisor pg_props u_pg_props (.clk, .rst, .fbBelowUv, .fbInsideUvHyst,
   .fbAboveOv, .fbInsideOvHyst, .overtempRising, .overtempFalling, .enableAboveRising,
   .enableAboveFalling, .supplyAboveLockout, .supplyAboveLockoutHyst, .hiccupRecover,
   .powerGoodFlagOut, .powerGoodFlagOe, .softStartActive);

// ### verification/power_good_supervisor_bench.sv
`timescale 1ns/1ps
module power_good_supervisor_bench;
   import pg_pkg::*;
   logic clk, rst, fbBelowUv, fbInsideUvHyst, fbAboveOv, fbInsideOvHyst, overtempRising;
   logic overtempFalling, enableAboveRising, enableAboveFalling, supplyAboveLockout;
   logic supplyAboveLockoutHyst, hiccupRecover, powerGoodFlagOut, powerGoodFlagOe;
   logic softStartActive;
   wire  pinLevel;
   int   fails = 0;
   int   compares = 0;
   power_good_supervisor u_power_good_supervisor (.clk, .rst, .fbBelowUv, .fbInsideUvHyst,
      .fbAboveOv, .fbInsideOvHyst, .overtempRising, .overtempFalling, .enableAboveRising,
      .enableAboveFalling, .supplyAboveLockout, .supplyAboveLockoutHyst, .hiccupRecover,
      .powerGoodFlagOut, .powerGoodFlagOe, .softStartActive);
   pg_pullup u_pg_pullup (.flagOut(powerGoodFlagOut), .flagOe(powerGoodFlagOe), .pinLevel);
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #(CLK_NS / 2) clk = ~clk;
   end
   // Inputs move 10 ns after the edge, clear of sampling
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask
   // One fault source on or off, every other input healthy
   task automatic drive(input int k, input logic on);
      {fbBelowUv, fbAboveOv, overtempRising, overtempFalling, hiccupRecover} = 5'h0;
      {fbInsideUvHyst, fbInsideOvHyst, enableAboveRising, enableAboveFalling} = 4'hf;
      {supplyAboveLockout, supplyAboveLockoutHyst} = 2'h3;
      if (on) begin
         case (k)
            0: {fbBelowUv, fbInsideUvHyst} = 2'h2;
            1: {fbAboveOv, fbInsideOvHyst} = 2'h2;
            2: {enableAboveRising, enableAboveFalling} = 2'h0;
            3: {overtempRising, overtempFalling} = 2'h3;
            4: {supplyAboveLockout, supplyAboveLockoutHyst} = 2'h0;
            6: {hiccupRecover, fbInsideUvHyst} = 2'h2;
            default: hiccupRecover = 1'b1;
         endcase
      end
   endtask
   // Flag must stay low for the whole release delay after the fault ends
   task automatic fault(input int k, input int len);
      drive(k, 1'b1);
      step(len);
      chk("flagInFault", 1'b0, pinLevel);
      drive(k, 1'b0);
      step(RELEASE_DELAY_CYC - 20);
      chk("flagEarly", 1'b0, pinLevel);
      step(60);
      chk("flagReleased", 1'b1, pinLevel);
   endtask
   task automatic testStartup();
      step(5);
      chk("flagInReset", 1'b0, pinLevel);
      chk("softInReset", 1'b1, softStartActive);
      step(1);
      rst = 1'b0;
      step(RELEASE_DELAY_CYC - 20);
      chk("flagEarly", 1'b0, pinLevel);
      step(60);
      chk("flagReleased", 1'b1, pinLevel);
      chk("softDone", 1'b0, softStartActive);
   endtask
   // Two short dips, longer than the filter together but not apart
   task automatic testGlitch();
      for (int i = 0; i < 2; i++) begin
         drive(0, 1'b1);
         step(FAULT_FILTER_CYC - 50);
         drive(0, 1'b0);
         step(2);
      end
      step(8);
      chk("flagAfterGlitch", 1'b1, pinLevel);
   endtask
   task automatic testSources();
      fault(0, FAULT_FILTER_CYC + 60);
      fault(1, FAULT_FILTER_CYC + 60);
      fault(2, 8);
      fault(3, 8);
      fault(4, 8);
      fault(5, 8);
   endtask
   // Enable drop inside the release delay restarts it from zero
   task automatic testRestart();
      drive(2, 1'b1);
      step(20);
      drive(2, 1'b0);
      step(1500);
      fault(2, 8);
   endtask
   // Output parked inside the hysteresis band: soft start ends on its limit
   task automatic testSoftLimit();
      drive(6, 1'b1);
      step(2);
      hiccupRecover = 1'b0;
      step(SOFT_LIMIT_CYC - 20);
      chk("softHeld", 1'b1, softStartActive);
      chk("flagInSoft", 1'b0, pinLevel);
      step(40);
      chk("softLimit", 1'b0, softStartActive);
      fault(2, 8);
   endtask
   task automatic results();
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog well past the roughly 76000 cycles the tests need
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      results();
   end
   initial begin
      rst = 1'b1;
      drive(0, 1'b0);
      testStartup();
      testGlitch();
      testSources();
      testRestart();
      testSoftLimit();
      results();
   end
endmodule
